/* rtl/ssp_defines.svh */
// Constants of the synchronous serial port: widths, depths, counts and status bit positions
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_DATA_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_MIN_BITS 5'h04
`define SSP_MIN_SIZE_CODE 4'h3
`define SSP_CMD_BITS 8
`define SSP_CMD_GAP_PERIODS 5'h01
`define SSP_RX_TIMEOUT_HALF 7'h40
`define SSP_RX_SERVICE_LEVEL 4'h4
`define SSP_IRQ_TX 0
`define SSP_IRQ_RX 1
`define SSP_IRQ_TIMEOUT 2
`define SSP_IRQ_OVERRUN 3
`define SSP_PRESCALE_MIN_HALF 7'h01
`endif

/* rtl/ssp_pkg.sv */
// Types of the synchronous serial port
package ssp_pkg;
    typedef enum logic [1:0]
    {
        SSP_IDLE = 2'b00,
        SSP_LEAD = 2'b01,
        SSP_RUN = 2'b11,
        SSP_TAIL = 2'b10
    } ssp_state_e;
    typedef enum logic [1:0]
    {
        SSP_FMT_PULSE = 2'b00,
        SSP_FMT_SPI = 2'b01,
        SSP_FMT_CMD = 2'b10
    } ssp_format_e;
endpackage : ssp_pkg

/* rtl/ssp_top.sv */
// Synchronous serial port: FIFO module and the serial engine top
// Function
// - Prescale system clock by even 2..254
// - Then divide by one plus rate field
// - Separate eight-deep 16-bit transmit, receive buffers
// - Write pushes transmit, read pops receive
// - Empty slave transmit resends eighth-last word
// - Transmit empty raises interrupt or DMA request
// - Four interrupt sources ORed into one
// - Mask bit one passes a source
// - Raw and masked interrupt state readable
// - Frames carry 4..16 bits, MSB first
// - Serial clock idle except during frames
// - Receive timeout when idle with data
// - Frame select low whole frame in SPI and command formats
// - Pulsed format: drive rising, sample falling
// - Command format sends 8-bit command, half duplex
// - Pulsed idle: clock, select low, output released
// - Pulsed start: select high one period
// - Pulsed receive word stored half a period after last falling as master, right after it as slave
// - Polarity bit sets idle clock level in SPI format
// - Phase bit picks first or second edge in SPI format
`timescale 1ns/100ps
`include "ssp_defines.svh"

module ssp_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data,
    output logic [AW:0] o_count
);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    assign o_in_ready = (o_count < (AW+1)'(DEPTH));
    assign o_out_valid = (o_count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    // When empty the head slot still holds the word written DEPTH pushes ago
    assign o_out_data = mem[rd_ptr];

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < DEPTH; k++)
                mem[k] <= '0;
        end
        else if (i_clear)
        begin
            for (int k = 0; k < DEPTH; k++)
                mem[k] <= '0;
        end
        else if (push)
            mem[wr_ptr] <= i_in_data;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_count <= '0;
        end
        else if (i_clear)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= rd_ptr + AW'(1);
            if (push && !pop)
                o_count <= o_count + (AW+1)'(1);
            else if (pop && !push)
                o_count <= o_count - (AW+1)'(1);
        end
    end

    fifo_bound_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : ssp_fifo

module ssp_top #(
    parameter int DATA_W = `SSP_DATA_W,
    parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH,
    parameter int CW = $clog2(FIFO_DEPTH)
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_module_clock_enable,
    input wire logic i_master_mode,
    input wire logic [1:0] i_frame_format,
    input wire logic i_clock_polarity_bit,
    input wire logic i_clock_phase_bit,
    input wire logic [3:0] i_data_size,
    input wire logic [7:0] i_clock_prescale_divisor,
    input wire logic [7:0] i_serial_rate_divider,
    input wire logic i_tx_dma_enable,
    input wire logic [3:0] i_interrupt_mask_reg,
    input wire logic [3:0] i_interrupt_clear,
    input wire logic i_data_wr_valid,
    output logic o_data_wr_ready,
    input wire logic [DATA_W-1:0] i_data_wr,
    output logic o_data_rd_valid,
    input wire logic i_data_rd_ready,
    output logic [DATA_W-1:0] o_data_rd,
    output logic [3:0] o_raw_interrupt_state,
    output logic [3:0] o_masked_interrupt_state,
    output logic o_interrupt,
    output logic o_tx_dma_req,
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_pin_oe,
    input wire logic i_frame_select_pin,
    output logic o_frame_select_pin,
    output logic o_frame_select_pin_oe,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe,
    input wire logic i_serial_in_pin
);
    ssp_pkg::ssp_state_e state;
    ssp_pkg::ssp_format_e fmt;
    logic [6:0] pre_half;
    logic [6:0] pre_cnt;
    logic [7:0] rate_cnt;
    logic pre_tick;
    logic half_tick;
    logic [4:0] nbits;
    logic [4:0] total_p;
    logic [4:0] cap_lo;
    logic [4:0] cap_hi;
    logic [4:0] sh_lo;
    logic [4:0] sh_hi;
    logic cap_lead;
    logic sh_lead;
    logic preload;
    logic idle_lvl;
    logic [5:0] ecnt;
    logic [4:0] per;
    logic lead;
    logic ev;
    logic last_ev;
    logic start_m;
    logic start_s_sel;
    logic start_s_pulse;
    logic abort_s;
    logic sclk;
    logic fss;
    logic tx_bit;
    logic sclk_prev;
    logic fss_prev;
    logic [DATA_W-1:0] tx_sh;
    logic [DATA_W-1:0] rx_sh;
    logic [DATA_W-1:0] tx_head;
    logic [DATA_W-1:0] tx_load;
    logic tx_valid;
    logic tx_pop;
    logic [CW:0] tx_count;
    logic rx_push_q;
    logic rx_in_ready;
    logic [CW:0] rx_count;
    logic [6:0] tout_cnt;
    logic tout_hit;
    logic timeout_flag;
    logic overrun_flag;

    // Command format is master only; a slave treats it as plain SPI
    assign fmt = (!i_master_mode && i_frame_format == 2'b10) ? ssp_pkg::SSP_FMT_SPI
               : (i_frame_format == 2'b00) ? ssp_pkg::SSP_FMT_PULSE
               : (i_frame_format == 2'b10) ? ssp_pkg::SSP_FMT_CMD : ssp_pkg::SSP_FMT_SPI;

    // Odd divisors lose their low bit so the prescale stays even
    assign pre_half = (i_clock_prescale_divisor[7:1] == 7'h00) ? `SSP_PRESCALE_MIN_HALF
                    : i_clock_prescale_divisor[7:1];
    assign pre_tick = (pre_cnt == pre_half - 7'h01);
    assign half_tick = pre_tick && (rate_cnt == i_serial_rate_divider);

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            pre_cnt <= 7'h00;
        else if (!i_enable || pre_tick)
            pre_cnt <= 7'h00;
        else
            pre_cnt <= pre_cnt + 7'h01;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rate_cnt <= 8'h00;
        else if (!i_enable || half_tick)
            rate_cnt <= 8'h00;
        else if (pre_tick)
            rate_cnt <= rate_cnt + 8'h01;
    end

    // Sizes below four bits are lifted to four
    assign nbits = (i_data_size < `SSP_MIN_SIZE_CODE) ? `SSP_MIN_BITS
                 : {1'b0, i_data_size} + 5'h01;

    always_comb
    begin
        total_p = nbits;
        cap_lead = 1'b1;
        cap_lo = 5'h00;
        cap_hi = nbits;
        sh_lead = 1'b0;
        sh_lo = 5'h00;
        sh_hi = nbits - 5'h01;
        preload = 1'b1;
        idle_lvl = 1'b0;
        case (fmt)
            ssp_pkg::SSP_FMT_PULSE:
            begin
                total_p = nbits + 5'h01;
                cap_lead = 1'b0;
                cap_lo = 5'h01;
                cap_hi = nbits + 5'h01;
                sh_lead = 1'b1;
                sh_lo = 5'h01;
                sh_hi = nbits + 5'h01;
                preload = 1'b0;
            end
            ssp_pkg::SSP_FMT_CMD:
            begin
                total_p = 5'(`SSP_CMD_BITS) + `SSP_CMD_GAP_PERIODS + nbits;
                cap_lo = 5'(`SSP_CMD_BITS) + `SSP_CMD_GAP_PERIODS;
                cap_hi = total_p;
                sh_hi = 5'(`SSP_CMD_BITS - 1);
            end
            ssp_pkg::SSP_FMT_SPI:
            begin
                idle_lvl = i_clock_polarity_bit;
                if (i_clock_phase_bit)
                begin
                    cap_lead = 1'b0;
                    sh_lead = 1'b1;
                    sh_hi = nbits;
                    preload = 1'b0;
                end
            end
            default:
                idle_lvl = 1'b0;
        endcase
    end

    // Slave edges come straight off the pin, hence the twelve-to-one clock margin
    assign per = ecnt[5:1];
    assign lead = !ecnt[0];
    assign ev = (state == ssp_pkg::SSP_RUN)
              && (i_master_mode ? half_tick : (i_serial_clock_pin != sclk_prev));
    assign last_ev = ev && (ecnt == {total_p, 1'b0} - 6'h01);
    // Select must be seen high for a cycle between words, or the slave keeps its old word
    assign start_m = i_master_mode && tx_valid && half_tick
                   && (fss || fmt == ssp_pkg::SSP_FMT_PULSE);
    assign start_s_sel = !i_master_mode && fmt != ssp_pkg::SSP_FMT_PULSE
                       && fss_prev && !i_frame_select_pin;
    assign start_s_pulse = !i_master_mode && fmt == ssp_pkg::SSP_FMT_PULSE
                         && !sclk_prev && i_serial_clock_pin && i_frame_select_pin;
    assign abort_s = !i_master_mode && fmt != ssp_pkg::SSP_FMT_PULSE && i_frame_select_pin;
    assign tx_pop = (state == ssp_pkg::SSP_IDLE) && i_enable
                  && (start_m || start_s_sel || start_s_pulse);
    // Command frames send only the low byte of the written word
    assign tx_load = (fmt == ssp_pkg::SSP_FMT_CMD)
                   ? {tx_head[`SSP_CMD_BITS-1:0], {(DATA_W-`SSP_CMD_BITS){1'b0}}}
                   : tx_head << (5'h10 - nbits);

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            state <= ssp_pkg::SSP_IDLE;
        else if (!i_enable)
            state <= ssp_pkg::SSP_IDLE;
        else
            case (state)
                ssp_pkg::SSP_IDLE:
                    if (start_m)
                        state <= (fmt == ssp_pkg::SSP_FMT_PULSE) ? ssp_pkg::SSP_RUN
                               : ssp_pkg::SSP_LEAD;
                    else if (start_s_sel || start_s_pulse)
                        state <= ssp_pkg::SSP_RUN;
                ssp_pkg::SSP_LEAD:
                    if (half_tick)
                        state <= ssp_pkg::SSP_RUN;
                ssp_pkg::SSP_RUN:
                    if (abort_s)
                        state <= ssp_pkg::SSP_IDLE;
                    else if (last_ev)
                        state <= i_master_mode ? ssp_pkg::SSP_TAIL : ssp_pkg::SSP_IDLE;
                ssp_pkg::SSP_TAIL:
                    if (half_tick)
                        state <= ssp_pkg::SSP_IDLE;
                default:
                    state <= ssp_pkg::SSP_IDLE;
            endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            ecnt <= 6'h00;
        else if (state == ssp_pkg::SSP_IDLE)
            ecnt <= start_s_pulse ? 6'h01 : 6'h00;
        else if (ev)
            ecnt <= ecnt + 6'h01;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_prev <= 1'b0;
            fss_prev <= 1'b1;
        end
        else
        begin
            sclk_prev <= i_serial_clock_pin;
            fss_prev <= i_frame_select_pin;
        end
    end

    // Master clock: held at its idle level outside frames
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            sclk <= 1'b0;
        else if (state == ssp_pkg::SSP_RUN && half_tick)
            sclk <= !sclk;
        else if (state != ssp_pkg::SSP_RUN)
            sclk <= idle_lvl;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            fss <= 1'b1;
        else if (fmt == ssp_pkg::SSP_FMT_PULSE)
        begin
            if (tx_pop && i_master_mode)
                fss <= 1'b1;
            else if (state != ssp_pkg::SSP_RUN || (ev && ecnt == 6'h01))
                fss <= 1'b0;
        end
        else
            fss <= (state == ssp_pkg::SSP_IDLE) && !(tx_pop && i_master_mode);
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_sh <= '0;
            tx_bit <= 1'b0;
        end
        else if (tx_pop)
        begin
            tx_sh <= preload ? (tx_load << 1) : tx_load;
            tx_bit <= preload ? tx_load[DATA_W-1] : 1'b0;
        end
        else if (ev && lead == sh_lead && per >= sh_lo)
        begin
            tx_bit <= (per < sh_hi) ? tx_sh[DATA_W-1] : 1'b0;
            tx_sh <= tx_sh << 1;
        end
    end

    // Bits outside the capture window, such as the command phase, are ignored
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rx_sh <= '0;
        else if (tx_pop)
            rx_sh <= '0;
        else if (ev && lead == cap_lead && per >= cap_lo && per < cap_hi)
            rx_sh <= {rx_sh[DATA_W-2:0], i_serial_in_pin};
    end

    // One cycle late so a capture on the final edge is in the word
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rx_push_q <= 1'b0;
        else
            rx_push_q <= i_enable && ((i_master_mode && state == ssp_pkg::SSP_TAIL
                       && half_tick) || (!i_master_mode && last_ev));
    end

    ssp_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clear(!i_module_clock_enable),
        .i_in_valid(i_data_wr_valid),
        .o_in_ready(o_data_wr_ready),
        .i_in_data(i_data_wr),
        .o_out_valid(tx_valid),
        .i_out_ready(tx_pop),
        .o_out_data(tx_head),
        .o_count(tx_count)
    );

    ssp_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clear(!i_module_clock_enable),
        .i_in_valid(rx_push_q),
        .o_in_ready(rx_in_ready),
        .i_in_data(rx_sh),
        .o_out_valid(o_data_rd_valid),
        .i_out_ready(i_data_rd_ready),
        .o_out_data(o_data_rd),
        .o_count(rx_count)
    );

    assign tout_hit = half_tick && state == ssp_pkg::SSP_IDLE && rx_count != '0
                    && tout_cnt == `SSP_RX_TIMEOUT_HALF - 7'h01;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            tout_cnt <= 7'h00;
        else if (state != ssp_pkg::SSP_IDLE || rx_count == '0 || rx_push_q || tout_hit)
            tout_cnt <= 7'h00;
        else if (half_tick)
            tout_cnt <= tout_cnt + 7'h01;
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            timeout_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end
        else
        begin
            timeout_flag <= tout_hit
                          || (timeout_flag && !i_interrupt_clear[`SSP_IRQ_TIMEOUT]);
            overrun_flag <= (rx_push_q && !rx_in_ready)
                          || (overrun_flag && !i_interrupt_clear[`SSP_IRQ_OVERRUN]);
        end
    end

    always_comb
    begin
        o_raw_interrupt_state = 4'h0;
        o_raw_interrupt_state[`SSP_IRQ_TX] = (tx_count == '0);
        o_raw_interrupt_state[`SSP_IRQ_RX] = (rx_count >= (CW+1)'(`SSP_RX_SERVICE_LEVEL));
        o_raw_interrupt_state[`SSP_IRQ_TIMEOUT] = timeout_flag;
        o_raw_interrupt_state[`SSP_IRQ_OVERRUN] = overrun_flag;
    end

    assign o_masked_interrupt_state = o_raw_interrupt_state & i_interrupt_mask_reg;
    assign o_interrupt = |o_masked_interrupt_state;
    assign o_tx_dma_req = i_enable && i_tx_dma_enable && (tx_count == '0);

    assign o_serial_clock_pin = sclk;
    assign o_serial_clock_pin_oe = i_enable && i_master_mode;
    assign o_frame_select_pin = fss;
    assign o_frame_select_pin_oe = i_enable && i_master_mode;
    assign o_serial_out_pin = tx_bit;
    assign o_serial_out_pin_oe = i_enable && (state != ssp_pkg::SSP_IDLE
                               || (i_master_mode && fmt != ssp_pkg::SSP_FMT_PULSE));

    pre_even_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (pre_tick && i_clock_prescale_divisor >= 8'h04 && $stable(i_clock_prescale_divisor))
        |=> !pre_tick)
        else $error("prescale tick too close");
    rate_div_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (half_tick && i_serial_rate_divider != 8'h00 && i_clock_prescale_divisor >= 8'h04)
        |=> !half_tick [*2])
        else $error("rate divider tick too close");
    wr_push_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_data_wr_valid && o_data_wr_ready && !tx_pop && i_module_clock_enable)
        |=> tx_count == $past(tx_count) + (CW+1)'(1))
        else $error("write did not push");
    dma_empty_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_tx_dma_req |-> (tx_count == '0 && i_tx_dma_enable))
        else $error("dma request without empty buffer");
    irq_or_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_interrupt |-> |(i_interrupt_mask_reg & o_raw_interrupt_state))
        else $error("interrupt without masked source");
    mask_block_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_interrupt_mask_reg == 4'h0) |-> !o_interrupt)
        else $error("masked interrupt leaked");
    masked_raw_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_masked_interrupt_state & ~o_raw_interrupt_state) == 4'h0)
        else $error("masked state not subset of raw");
    idle_clock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ssp_pkg::SSP_IDLE && $past(state) == ssp_pkg::SSP_IDLE
        && $stable(idle_lvl)) |-> sclk == idle_lvl)
        else $error("serial clock not idle");
    frame_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_master_mode && fmt != ssp_pkg::SSP_FMT_PULSE && state == ssp_pkg::SSP_RUN)
        |-> !fss)
        else $error("frame select high during frame");
    pulse_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_master_mode && fmt == ssp_pkg::SSP_FMT_PULSE && fss)
        |-> (state == ssp_pkg::SSP_RUN && ecnt < 6'h02))
        else $error("pulse select too long");
    pulse_hiz_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (fmt == ssp_pkg::SSP_FMT_PULSE && state == ssp_pkg::SSP_IDLE) |-> !o_serial_out_pin_oe)
        else $error("output driven while pulsed idle");
    timeout_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        tout_hit |=> o_raw_interrupt_state[`SSP_IRQ_TIMEOUT])
        else $error("timeout not flagged");
    overrun_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (rx_push_q && !rx_in_ready) |=> (overrun_flag && $stable(rx_count)))
        else $error("overrun not flagged or word stored");

    spi_frame_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        fmt == ssp_pkg::SSP_FMT_SPI && i_master_mode && rx_push_q);
    pulse_frame_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        fmt == ssp_pkg::SSP_FMT_PULSE && rx_push_q);
    cmd_frame_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        fmt == ssp_pkg::SSP_FMT_CMD && rx_push_q);
    overrun_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        rx_push_q && !rx_in_ready);
    timeout_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) tout_hit);
endmodule : ssp_top

/* testbench/ssp_slave_model.sv */
// Remote serial slave, clock polarity 0 and phase 0
`timescale 1ns/100ps
module ssp_slave_model #(
    parameter int N = 8
) (
    input wire logic i_sclk,
    input wire logic i_fss_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic [15:0] o_got
);
    logic [15:0] sh = 16'h0000;
    initial o_got = 16'h0000;
    // Reply is the inverse of the last word taken, so the bench can predict it
    always @(negedge i_fss_n) sh = ~o_got << (16 - N);
    always @(posedge i_sclk) if (!i_fss_n) o_got = {o_got[14:0], i_mosi};
    always @(negedge i_sclk) if (!i_fss_n) sh = sh << 1;
    // Deselected line shows a changed level, not a held one
    assign o_miso = i_fss_n ? ~sh[15] : sh[15];
endmodule : ssp_slave_model

/* testbench/synchronous_serial_port_test.sv */
// Self-checking bench of the serial port as SPI master
`timescale 1ns/100ps
module synchronous_serial_port_test;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic en = 1'b0;
    logic wv = 1'b0;
    logic rr = 1'b0;
    logic [3:0] msk = 4'h0;
    logic [3:0] clr = 4'h0;
    logic mce = 1'b1;
    logic dmae = 1'b1;
    logic [7:0] pre = 8'h02;
    logic [7:0] rate = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [15:0] sd = 16'h518B;
    logic [15:0] tx [0:8];
    logic wr_rdy, rd_v, irq, dma, sclk, fss, so, miso;
    logic [15:0] rd, got;
    logic [3:0] raw, mis;
    int mismatches = 0;
    int num_checks = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    ssp_top i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_enable(en),
        .i_module_clock_enable(mce), .i_master_mode(1'b1), .i_frame_format(2'b01),
        .i_clock_polarity_bit(1'b0), .i_clock_phase_bit(1'b0), .i_data_size(4'h7),
        .i_clock_prescale_divisor(pre), .i_serial_rate_divider(rate),
        .i_tx_dma_enable(dmae), .i_interrupt_mask_reg(msk), .i_interrupt_clear(clr),
        .i_data_wr_valid(wv), .o_data_wr_ready(wr_rdy), .i_data_wr(wd),
        .o_data_rd_valid(rd_v), .i_data_rd_ready(rr), .o_data_rd(rd),
        .o_raw_interrupt_state(raw), .o_masked_interrupt_state(mis), .o_interrupt(irq),
        .o_tx_dma_req(dma), .i_serial_clock_pin(sclk), .o_serial_clock_pin(sclk),
        .o_serial_clock_pin_oe(), .i_frame_select_pin(fss), .o_frame_select_pin(fss),
        .o_frame_select_pin_oe(), .o_serial_out_pin(so), .o_serial_out_pin_oe(),
        .i_serial_in_pin(miso));
    ssp_slave_model #(.N(8)) i_slave (.i_sclk(sclk), .i_fss_n(fss), .i_mosi(so),
        .o_miso(miso), .o_got(got));
    function logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function logic [15:0] exp_rx(input int i);
        return (i == 0) ? 16'h00FF : {8'h00, ~tx[i-1][7:0]};
    endfunction : exp_rx
    task chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task finish_test;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task wait_for(input int k);
        int n;
        n = 0;
        while (!(k == 0 ? raw[0] === 1'b1 : k == 1 ? fss === 1'b1 : raw[2] === 1'b1))
        begin
            @(negedge i_ref_clk);
            n++;
            if (n > 2000)
            begin
                mismatches++;
                finish_test();
            end
        end
    endtask : wait_for
    // Frame select falls at the same edge as the last pop, so it is low once the buffer reads empty
    task drain;
        wait_for(0);
        repeat (2) @(negedge i_ref_clk);
        wait_for(1);
        repeat (4) @(negedge i_ref_clk);
    endtask : drain
    initial
    begin
        repeat (10) @(negedge i_ref_clk);
        i_rst = 1'b0;
        chk(raw[0], 1'b1);
        wv = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            sd = lfsr(sd);
            tx[i] = sd;
            wd = sd;
            @(negedge i_ref_clk);
        end
        wv = 1'b0;
        chk(wr_rdy, 1'b0);
        chk(raw[0], 1'b0);
        chk(sclk, 1'b0);
        $display("test fill done");
        en = 1'b1;
        msk = 4'hF;
        drain();
        chk(dma, 1'b1);
        chk(raw[1], 1'b1);
        chk(irq, 1'b1);
        chk(got[7:0], tx[7][7:0]);
        chk(sclk, 1'b0);
        chk(fss, 1'b1);
        $display("test frames done");
        en = 1'b0;
        pre = 8'h04;
        rate = 8'h01;
        @(negedge i_ref_clk);
        en = 1'b1;
        sd = lfsr(sd);
        tx[8] = sd;
        wd = sd;
        wv = 1'b1;
        @(negedge i_ref_clk);
        wv = 1'b0;
        drain();
        chk(raw[3], 1'b1);
        chk(got[7:0], tx[8][7:0]);
        msk = 4'h8;
        #1;
        chk(mis, 4'h8);
        chk(irq, 1'b1);
        msk = 4'h3;
        #1;
        chk(mis, 4'h3);
        msk = 4'h0;
        #1;
        chk(irq, 1'b0);
        wait_for(2);
        chk(raw[2], 1'b1);
        clr = 4'h8;
        @(negedge i_ref_clk);
        clr = 4'h0;
        @(negedge i_ref_clk);
        chk(raw[3], 1'b0);
        $display("test flags done");
        rr = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            chk(rd, exp_rx(i));
            @(negedge i_ref_clk);
        end
        rr = 1'b0;
        chk(rd_v, 1'b0);
        $display("test read done");
        dmae = 1'b0;
        @(negedge i_ref_clk);
        chk(dma, 1'b0);
        en = 1'b0;
        wv = 1'b1;
        @(negedge i_ref_clk);
        wv = 1'b0;
        chk(raw[0], 1'b0);
        mce = 1'b0;
        @(negedge i_ref_clk);
        chk(raw[0], 1'b1);
        $display("test clear done");
        finish_test();
    end
endmodule : synchronous_serial_port_test
